//--- verilog/mode_select_and_irq_pins.v
// pin front end: mode-select pair, test reset, device reset, nmi, four gpio/irq pins
// assumes a 50 MHz clk_sys; pins are treated as synchronous to it
//
// The register addresses and strobed register access were chosen for this implementation.
`timescale 1ns/1ps

`include "mode_irq_defines.vh"

// What this block does
// - decode mode pair: 00 boundary-scan, 11 emulation default, 01/10 reserved
// - functional operation allowed in both boundary-scan and emulation modes
// - every rising nmi edge pulses nmiEvent unmasked, noise included; in irqOut it is masked by enable bit 0
// - four gpio pins also act as edge-triggered external interrupts
// - four-bit polarity field picks the trigger edge per pin
// - test reset resets the test port only, apart from device reset
module mode_select_and_irq_pins (
  // clock and reset
  input  wire        clk_sys,
  input  wire        arst_n,
  // mode and reset pins
  input  wire [1:0]  modeSelectPair,
  input  wire        testRst_n,
  input  wire        devResetPin_n,
  // interrupt pins
  input  wire        nmiPin,
  // gpio / external interrupt pins
  input  wire [3:0]  gpioIn,
  output reg  [3:0]  gpioOut,
  output reg  [3:0]  gpioOe_n,
  // register port
  input  wire [7:0]  regAddr,
  input  wire [31:0] regWdata,
  input  wire        regWr,
  input  wire        regRd,
  output reg  [31:0] regRdata,
  // to core mode logic
  output reg         boundaryScanSel,
  output reg         emulationSel,
  output reg         functionalEn,
  output reg         modeReserved,
  output reg         testPortRst_n,
  output reg         coreRst_n,
  output reg         scanEntry,
  // to core interrupt logic
  output reg         nmiEvent,
  output reg  [3:0]  extIrqEvent,
  output wire        irqOut
);

  // ************************************************************
  // registers
  // ************************************************************
  reg  [1:0]  modePair_ff;
  reg  [3:0]  polarity_ff;
  reg  [4:0]  irqStatus_ff;
  reg  [4:0]  irqEnable_ff;
  reg         trstHeld_ff;
  reg  [4:0]  nxt_irqStatus;
  reg  [31:0] nxt_rdata;
  wire [4:0]  rawLevel;
  wire [4:0]  rawEvent;
  wire [4:0]  edgeSel;
  wire        wrPolarity;
  wire        wrClear;
  wire        wrEnable;
  wire        wrGpioOut;
  wire        wrGpioDir;

  assign wrPolarity = regWr && (regAddr == `ADDR_POLARITY);
  assign wrClear    = regWr && (regAddr == `ADDR_IRQ_CLEAR);
  assign wrEnable   = regWr && (regAddr == `ADDR_IRQ_ENABLE);
  assign wrGpioOut  = regWr && (regAddr == `ADDR_GPIO_OUT);
  assign wrGpioDir  = regWr && (regAddr == `ADDR_GPIO_DIR);

  // ************************************************************
  // edge detection
  // ************************************************************
  // nmi always rising edge
  assign edgeSel = {polarity_ff, 1'b0};

  edge_event_detector #(
    .WIDTH (`IRQ_BITS)
  ) uEdges (
    .clk_sys   (clk_sys),
    .arst_n    (arst_n),
    .pinIn     ({gpioIn, nmiPin}),
    .fallSel   (edgeSel),
    .pinLevel  (rawLevel),
    .edgeEvent (rawEvent)
  );

  // ************************************************************
  // event outputs and sticky status
  // ************************************************************
  // set wins over a clear in the same cycle so no edge is lost
  always @* begin
    nxt_irqStatus = (irqStatus_ff & ~(wrClear ? regWdata[4:0] : 5'h00)) | rawEvent;
  end

  assign irqOut = |(irqStatus_ff & irqEnable_ff);

  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      irqStatus_ff <= 5'h00;
      nmiEvent     <= 1'b0;
      extIrqEvent  <= 4'h0;
    end else begin
      irqStatus_ff <= nxt_irqStatus;
      nmiEvent     <= rawEvent[`IRQ_NMI_BIT];
      extIrqEvent  <= rawEvent[4:1];
    end
  end

  // ************************************************************
  // mode decode and resets
  // ************************************************************
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      modePair_ff     <= `RST_MODE_PAIR;
      boundaryScanSel <= 1'b0;
      emulationSel    <= 1'b1;
      functionalEn    <= 1'b1;
      modeReserved    <= 1'b0;
      testPortRst_n   <= 1'b0;
      coreRst_n       <= 1'b0;
      scanEntry       <= 1'b0;
      trstHeld_ff     <= 1'b1;
    end else begin
      modePair_ff     <= modeSelectPair;
      boundaryScanSel <= (modePair_ff == `MODE_BOUNDARY_SCAN);
      emulationSel    <= (modePair_ff == `MODE_EMULATION);
      modeReserved    <= (modePair_ff == `MODE_RESERVED_1) ||
                         (modePair_ff == `MODE_RESERVED_2);
      functionalEn    <= (modePair_ff == `MODE_BOUNDARY_SCAN) ||
                         (modePair_ff == `MODE_EMULATION);
      testPortRst_n   <= testRst_n;
      coreRst_n       <= devResetPin_n;
      // scan entry needs pair and reset low
      scanEntry       <= (modePair_ff == `MODE_BOUNDARY_SCAN) && !devResetPin_n;
      // shows whether test reset stays low
      trstHeld_ff     <= !testRst_n;
    end
  end

  // ************************************************************
  // register file
  // ************************************************************
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      polarity_ff  <= `RST_POLARITY;
      irqEnable_ff <= `RST_IRQ_ENABLE;
      gpioOut      <= `RST_GPIO_OUT;
      gpioOe_n     <= ~`RST_GPIO_DIR;
    end else begin
      if (wrPolarity) begin
        polarity_ff <= regWdata[3:0];
      end
      if (wrEnable) begin
        irqEnable_ff <= regWdata[4:0];
      end
      if (wrGpioOut) begin
        gpioOut <= regWdata[3:0];
      end
      // direction bit 1 drives the pin; enable is low while driving
      if (wrGpioDir) begin
        gpioOe_n <= ~regWdata[3:0];
      end
    end
  end

  always @* begin
    nxt_rdata = 32'h00000000;
    case (regAddr)
      `ADDR_MODE_STATUS: begin
        nxt_rdata[`MS_BOUNDARY_BIT]   = boundaryScanSel;
        nxt_rdata[`MS_EMULATION_BIT]  = emulationSel;
        nxt_rdata[`MS_FUNCTIONAL_BIT] = functionalEn;
        nxt_rdata[`MS_RESERVED_BIT]   = modeReserved;
        nxt_rdata[5:4]                = modePair_ff;
        nxt_rdata[`MS_TEST_RST_BIT]   = testPortRst_n;
        nxt_rdata[`MS_SCAN_ENTRY_BIT] = scanEntry;
        nxt_rdata[`MS_TRST_HELD_BIT]  = trstHeld_ff;
      end
      `ADDR_POLARITY: begin
        nxt_rdata[3:0] = polarity_ff;
      end
      `ADDR_IRQ_STATUS: begin
        nxt_rdata[4:0] = irqStatus_ff;
      end
      `ADDR_IRQ_ENABLE: begin
        nxt_rdata[4:0] = irqEnable_ff;
      end
      `ADDR_GPIO_OUT: begin
        nxt_rdata[3:0] = gpioOut;
      end
      `ADDR_GPIO_DIR: begin
        nxt_rdata[3:0] = ~gpioOe_n;
      end
      `ADDR_GPIO_IN: begin
        nxt_rdata[3:0] = rawLevel[4:1];
      end
      default: begin
        nxt_rdata = 32'h00000000;
      end
    endcase
  end

  // read data stand only in the cycle after the strobe
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      regRdata <= 32'h00000000;
    end else if (regRd) begin
      regRdata <= nxt_rdata;
    end else begin
      regRdata <= 32'h00000000;
    end
  end

endmodule

//--- pkg/mode_irq_defines.vh
// constants for the mode-select and interrupt pin front end
// assumes a 50 MHz core clock and a byte-addressed 32-bit register port
`ifndef MODE_IRQ_DEFINES_VH
`define MODE_IRQ_DEFINES_VH

// ************************************************************
// register offsets
// ************************************************************
`define ADDR_MODE_STATUS   8'h00
`define ADDR_POLARITY      8'h04
`define ADDR_IRQ_STATUS    8'h08
`define ADDR_IRQ_CLEAR     8'h0C
`define ADDR_IRQ_ENABLE    8'h10
`define ADDR_GPIO_OUT      8'h14
`define ADDR_GPIO_DIR      8'h18
`define ADDR_GPIO_IN       8'h1C

// ************************************************************
// mode codes on the mode-select pair
// ************************************************************
`define MODE_BOUNDARY_SCAN 2'h0
`define MODE_RESERVED_1    2'h1
`define MODE_RESERVED_2    2'h2
`define MODE_EMULATION     2'h3

// ************************************************************
// field positions and widths
// ************************************************************
`define EXT_IRQ_COUNT      4
`define IRQ_BITS           5
`define IRQ_NMI_BIT        0
`define IRQ_EXT_LSB        1
`define MS_BOUNDARY_BIT    0
`define MS_EMULATION_BIT   1
`define MS_FUNCTIONAL_BIT  2
`define MS_RESERVED_BIT    3
`define MS_PAIR_LSB        4
`define MS_TEST_RST_BIT    6
`define MS_SCAN_ENTRY_BIT  7
`define MS_TRST_HELD_BIT   8

// ************************************************************
// reset values
// ************************************************************
`define RST_POLARITY       4'h0
`define RST_IRQ_ENABLE     5'h00
`define RST_GPIO_OUT       4'h0
`define RST_GPIO_DIR       4'h0
`define RST_MODE_PAIR      2'h3

`endif

//--- verilog/edge_event_detector.v
// per-bit two-flop synchroniser plus edge detector with selectable edge
// assumes inputs synchronous-ish pins; first flop feeds only the second
`timescale 1ns/1ps

module edge_event_detector #(
  parameter WIDTH = 5
) (
  // clock and reset
  input  wire             clk_sys,
  input  wire             arst_n,
  // pins and edge choice (0 rising, 1 falling)
  input  wire [WIDTH-1:0] pinIn,
  input  wire [WIDTH-1:0] fallSel,
  // results
  output wire [WIDTH-1:0] pinLevel,
  output wire [WIDTH-1:0] edgeEvent
);

  genvar i;

  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : gBit
      reg syncA_ff;
      reg syncB_ff;
      reg prev_ff;
      reg event_ff;
      wire nxt_event;

      assign nxt_event = fallSel[i] ? (prev_ff & ~syncB_ff) : (~prev_ff & syncB_ff);

      always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
          syncA_ff <= 1'b0;
          syncB_ff <= 1'b0;
          prev_ff  <= 1'b0;
          event_ff <= 1'b0;
        end else begin
          syncA_ff <= pinIn[i];
          syncB_ff <= syncA_ff;
          prev_ff  <= syncB_ff;
          event_ff <= nxt_event;
        end
      end

      assign pinLevel[i]  = prev_ff;
      assign edgeEvent[i] = event_ff;
    end
  endgenerate

endmodule

//--- tb/mode_irq_properties.sv
// port-level assertions for the mode-select and interrupt pin front end
// assumes it is bound to the design top and sees only its ports
`timescale 1ns/1ps
module mode_irq_properties (
  // clock and reset
  input wire logic       clk_sys,
  input wire logic       arst_n,
  // pins and register strobe
  input wire logic [1:0] modeSelectPair,
  input wire logic       testRst_n,
  input wire logic       devResetPin_n,
  input wire logic       nmiPin,
  input wire logic       regWr,
  // results
  input wire logic       boundaryScanSel,
  input wire logic       emulationSel,
  input wire logic       functionalEn,
  input wire logic       modeReserved,
  input wire logic       testPortRst_n,
  input wire logic       coreRst_n,
  input wire logic       scanEntry,
  input wire logic       nmiEvent,
  input wire logic [3:0] extIrqEvent,
  input wire logic       irqOut
);
  // *****
  // properties
  // *****
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  AST_MODE_SCAN: assert property (
    (modeSelectPair == 2'h0)[*3] |-> boundaryScanSel && !emulationSel && functionalEn)
    else $error("scan decode");
  AST_MODE_EMU: assert property (
    (modeSelectPair == 2'h3)[*3] |-> emulationSel && !boundaryScanSel && functionalEn)
    else $error("emulation decode");
  AST_MODE_RSV: assert property (
    (^modeSelectPair)[*3] |-> modeReserved && !functionalEn) else $error("reserved decode");
  AST_SCAN_ENTRY: assert property (
    (modeSelectPair == 2'h0 && !devResetPin_n)[*3] |-> scanEntry) else $error("scan entry");
  AST_TEST_RST: assert property (
    (testRst_n && !devResetPin_n)[*2] |-> testPortRst_n && !coreRst_n) else $error("test rst");
  AST_NMI_RISE: assert property (
    $rose(nmiPin) |-> ##[2:4] nmiEvent) else $error("nmi missed");
  AST_NMI_PULSE: assert property (
    nmiEvent |=> !nmiEvent) else $error("nmi pulse long");
  AST_EXT_PULSE: assert property (
    extIrqEvent != 4'h0 |=> (extIrqEvent & $past(extIrqEvent)) == 4'h0)
    else $error("ext pulse long");
  AST_IRQ_CAUSE: assert property (
    $rose(irqOut) |-> nmiEvent || extIrqEvent != 4'h0 || $past(regWr))
    else $error("irq without cause");
  cover property (nmiEvent);
  cover property (extIrqEvent != 4'h0);
  cover property (scanEntry);
endmodule

bind mode_select_and_irq_pins mode_irq_properties mode_irq_properties_i (
  .clk_sys, .arst_n, .modeSelectPair, .testRst_n, .devResetPin_n, .nmiPin, .regWr,
  .boundaryScanSel, .emulationSel, .functionalEn, .modeReserved, .testPortRst_n,
  .coreRst_n, .scanEntry, .nmiEvent, .extIrqEvent, .irqOut);

//--- tb/pin_stimulus_model.sv
// stand-in for board straps, test controller and interrupt sources
// assumes bench requests change right after clk_sys edges
`timescale 1ns/1ps
module pin_stimulus_model (
  // bench side
  input  wire logic       clk_sys,
  input  wire logic [1:0] pairReq,
  input  wire logic       scanReq,
  input  wire logic       rstReq,
  input  wire logic       nmiReq,
  input  wire logic [3:0] irqReq,
  // design side
  input  wire logic [3:0] gpioOut,
  input  wire logic [3:0] gpioOe_n,
  output logic      [1:0] modeSelectPair = 2'h3,
  output logic            testRst_n = 1'b1,
  output logic            devResetPin_n = 1'b1,
  output logic            nmiPin = 1'b0,
  output wire logic [3:0] gpioIn
);
  // *****
  // pin drive
  // *****
  always @(posedge clk_sys) begin
    modeSelectPair <= scanReq ? 2'h0 : pairReq;
    devResetPin_n <= !(scanReq || rstReq);
    testRst_n <= !(scanReq || pairReq == 2'h0);
    nmiPin <= nmiReq;
  end
  // undriven pins follow the interrupt source
  assign gpioIn = (gpioOut & ~gpioOe_n) | (irqReq & gpioOe_n);
endmodule

//--- tb/mode_select_and_irq_pins_tb.sv
// self-checking bench for the mode-select and interrupt pin front end
// assumes the partner model drives every pin of the design
`timescale 1ns/1ps
`include "mode_irq_defines.vh"
module mode_select_and_irq_pins_tb;
  logic        clk_sys = 0, arst_n = 0, regWr = 0, regRd = 0, scanReq = 0, rstReq = 0;
  logic        nmiReq = 0, testRst_n, devResetPin_n, nmiPin, boundaryScanSel, emulationSel;
  logic        functionalEn, modeReserved, testPortRst_n, coreRst_n, scanEntry, nmiEvent;
  logic        irqOut;
  logic [1:0]  pairReq = 2'h3, modeSelectPair;
  logic [3:0]  irqReq = 4'h0, pol, gpioIn, gpioOut, gpioOe_n, extIrqEvent;
  logic [7:0]  regAddr = 8'h00, nmiCnt = 8'h00, extCnt = 8'h00;
  logic [15:0] lf = 16'hC47E;
  logic [31:0] regWdata = 32'h0, regRdata, d;
  int          errors = 0, num_checks = 0, i, j;
  // *****
  // plumbing
  // *****
  always #10 clk_sys = ~clk_sys;
  // counters held clear in reset: event outputs are unknown before the first edge
  always @(posedge clk_sys) nmiCnt <= arst_n ? nmiCnt + {7'h0, nmiEvent} : 8'h00;
  always @(posedge clk_sys) extCnt <= arst_n ? extCnt + {7'h0, |extIrqEvent} : 8'h00;
  mode_select_and_irq_pins mode_select_and_irq_pins_i (.clk_sys, .arst_n, .modeSelectPair,
    .testRst_n, .devResetPin_n, .nmiPin, .gpioIn, .gpioOut, .gpioOe_n, .regAddr, .regWdata,
    .regWr, .regRd, .regRdata, .boundaryScanSel, .emulationSel, .functionalEn, .modeReserved,
    .testPortRst_n, .coreRst_n, .scanEntry, .nmiEvent, .extIrqEvent, .irqOut);
  pin_stimulus_model pin_stimulus_model_i (.clk_sys, .pairReq, .scanReq, .rstReq, .nmiReq,
    .irqReq, .gpioOut, .gpioOe_n, .modeSelectPair, .testRst_n, .devResetPin_n, .nmiPin,
    .gpioIn);
  function automatic logic [15:0] nxt(input logic [15:0] v);
    nxt = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  // {reserved, functional, emulation, scan}
  function automatic logic [3:0] modeExp(input logic [1:0] p);
    modeExp = {p[1] ^ p[0], p[1] ~^ p[0], p == 2'h3, p == 2'h0};
  endfunction
  task automatic chk(input string n, input logic [31:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= v;
    @(posedge clk_sys);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk_sys);
    regRd <= 1'b0;
    @(negedge clk_sys);
    d = regRdata;
    @(posedge clk_sys);
  endtask
  task automatic give_verdict;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // *****
  // scenarios
  // *****
  initial begin
    #50000;
    errors++;
    give_verdict();
  end
  initial begin
    cyc(5);
    chk("rst", {emulationSel, functionalEn, gpioOe_n, irqOut}, 7'h7E);
    arst_n <= 1'b1;
    for (i = 0; i < 4; i++) begin
      pairReq <= 2'(i);
      cyc(5);
      rd(`ADDR_MODE_STATUS);
      chk("mode", d[8:0], {(i == 0), 1'h0, (i != 0), 2'(i), modeExp(2'(i))});
    end
    scanReq <= 1'b1;
    cyc(5);
    chk("scan", {scanEntry, coreRst_n, testPortRst_n}, 3'h4);
    scanReq <= 1'b0;
    rstReq <= 1'b1;
    cyc(5);
    chk("trst", {scanEntry, coreRst_n, testPortRst_n}, 3'h1);
    rstReq <= 1'b0;
    wr(`ADDR_IRQ_ENABLE, 32'h1);
    // noise-like train: every rise counts, falls do not
    for (i = 0; i < 3; i++) begin
      nmiReq <= 1'b1;
      cyc(1);
      nmiReq <= 1'b0;
      cyc(1);
    end
    cyc(6);
    chk("nmi", {nmiCnt, irqOut}, {8'h3, 1'b1});
    rd(`ADDR_IRQ_STATUS);
    chk("nmiStat", d, 32'h1);
    lf = nxt(lf);
    pol = lf[3:0];
    for (j = 0; j < 2; j++) begin
      wr(`ADDR_POLARITY, {28'h0, pol});
      rd(`ADDR_POLARITY);
      chk("pol", d, {28'h0, pol});
      irqReq <= pol;
      cyc(6);
      wr(`ADDR_IRQ_CLEAR, 32'h1F);
      for (i = 0; i < 4; i++) begin
        irqReq[i] <= ~pol[i];
        cyc(6);
        rd(`ADDR_IRQ_STATUS);
        chk("ext", {irqOut, d[4:0]}, 6'h2 << i);
        wr(`ADDR_IRQ_CLEAR, 32'h1F);
        irqReq[i] <= pol[i];
        cyc(6);
        rd(`ADDR_IRQ_STATUS);
        chk("wrongEdge", d, 32'h0);
      end
      pol = ~pol;
    end
    chk("extCnt", extCnt, 8'h8);
    lf = nxt(lf);
    wr(`ADDR_GPIO_DIR, 32'hF);
    wr(`ADDR_GPIO_OUT, {28'h0, lf[3:0]});
    cyc(4);
    chk("gpo", {gpioOe_n, gpioOut}, {4'h0, lf[3:0]});
    rd(`ADDR_GPIO_IN);
    chk("gpi", d, {28'h0, lf[3:0]});
    rd(8'hFC);
    chk("unmapped", d, 32'h0);
    give_verdict();
  end
endmodule
